// ### verilog/cerq_top.sv
// Function
// - Sources are exposure end and queue overrun
// - Records only while reporting is enabled
// - Each record carries its type code
// - Stream channel field always zero
// - Frame number captured at event time
// - Thirty-two bit timestamp captured at event
// - New records go into queue first
// - Send message when slot and records exist
// - One queued record gives single record message
// - Several queued records share one message
// - Full queue drops events, flags overrun
// - Overrun record queued only when enabled
// - Overrun record sent at next slot
// - Overrun record carries no loss details
`timescale 1ns/1ns
`default_nettype none
module cerq_top import cerq_pkg::*; #(
  parameter int unsigned DEPTH = QUEUE_DEPTH,
  parameter int unsigned CW    = $clog2(DEPTH + 1)
) (
  input  wire logic               clk,           // 10 MHz system clock
  input  wire logic               rst,           // Synchronous reset, high
  input  wire logic               expo_done,     // Exposure finished, one cycle
  input  wire logic [FRAME_W-1:0] frame_cnt,     // Running frame counter
  input  wire logic               rpt_expo_en,   // Exposure end reporting on
  input  wire logic               rpt_ovr_en,    // Overrun reporting on
  input  wire logic               bus_slot,      // Bus time available, pin
  input  wire logic               bus_rdy,       // Bus accepts a record, pin
  input  wire logic               host_ack,      // Host acknowledge, pin
  output var  logic               rec_valid_ff,  // Record word on bus
  output var  cerq_rec_t          rec_data_ff,   // Record contents
  output var  logic               msg_sop_ff,    // First record of message
  output var  logic               msg_eop_ff,    // Last record of message
  output var  logic [CW-1:0]      msg_nrec_ff,   // Records in this message
  output var  logic               msg_busy_ff,   // Message sent or awaiting ack
  output var  logic               overrun_ff     // Events being dropped
);

  cerq_state_t     state_ff;
  cerq_state_t     nxt_state;
  logic [CW-1:0]   left_ff;
  logic [STAMP_W-1:0] ts_ff;
  logic            ovr_lat_ff;
  logic [2:0]      link_s;
  logic            slot_s;
  logic            rdy_s;
  logic            ack_s;
  logic            ack_d_ff;
  logic            ack_rise;
  cerq_rec_t       push_rec;
  cerq_rec_t       pop_rec;
  logic            push_valid;
  logic            push_ready;
  logic            pop_valid;
  logic            pop_ready;
  logic [CW-1:0]   q_cnt;
  logic            expo_evt;
  logic            room_normal;
  logic            expo_take;
  logic            expo_drop;
  logic            ovr_push;

  // Link pins pass two flip-flops first
  cerq_sync2 #(.W(3)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({bus_slot, bus_rdy, host_ack}),
    .dout (link_s)
  );
  assign slot_s = link_s[2];
  assign rdy_s  = link_s[1];
  assign ack_s  = link_s[0];

  // Acknowledge taken on its rising edge; a level left high would end the next message early
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_d_ff <= 1'b0;
    end else begin
      ack_d_ff <= ack_s;
    end
  end

  assign ack_rise = ack_s && !ack_d_ff;

  // Free running timestamp
  always_ff @(posedge clk) begin
    if (rst) begin
      ts_ff <= STAMP_RST;
    end else begin
      ts_ff <= ts_ff + STAMP_W'(1);
    end
  end

  // Admission: the last slot is held back for an overrun record
  assign expo_evt    = expo_done && rpt_expo_en;
  assign room_normal = (q_cnt < CW'(DEPTH - 1));
  assign expo_take   = expo_evt && room_normal;
  assign expo_drop   = expo_evt && !room_normal;
  assign ovr_push    = expo_drop && !ovr_lat_ff && rpt_ovr_en;
  assign push_valid  = expo_take || ovr_push;

  // Record builder; overrun carries type, channel, frame and stamp, no loss details
  always_comb begin
    push_rec.kind  = ovr_push ? KIND_OVERRUN : KIND_EXPO_END;
    push_rec.chan  = CHAN_ID;
    push_rec.frame = frame_cnt;
    push_rec.stamp = ts_ff;
  end

  // Overrun latch, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ovr_lat_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else if (expo_drop) begin
      ovr_lat_ff <= 1'b1;
      overrun_ff <= 1'b1;
    end else if (room_normal) begin
      ovr_lat_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end
  end

  // Event queue, oldest record first
  cerq_fifo #(.W(REC_W), .D(DEPTH), .CW(CW)) u_queue (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_rec),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_rec),
    .count     (q_cnt)
  );

  // Drain only while sending and the bus takes a record
  assign pop_ready = (state_ff == ST_SEND) && rdy_s && (left_ff != '0);

  // Framer next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (slot_s && q_cnt != '0) begin
          nxt_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (pop_ready && pop_valid && left_ff == CW'(1)) begin
          nxt_state = ST_WACK;
        end
      end
      ST_WACK: begin
        if (ack_rise) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Snapshot every queued record into one message
  always_ff @(posedge clk) begin
    if (rst) begin
      left_ff     <= '0;
      msg_nrec_ff <= '0;
    end else if (state_ff == ST_IDLE && nxt_state == ST_SEND) begin
      left_ff     <= q_cnt;
      msg_nrec_ff <= q_cnt;
    end else if (pop_ready && pop_valid) begin
      left_ff <= left_ff - CW'(1);
    end
  end

  // Record output stage
  always_ff @(posedge clk) begin
    if (rst) begin
      rec_valid_ff <= 1'b0;
      rec_data_ff  <= '0;
      msg_sop_ff   <= 1'b0;
      msg_eop_ff   <= 1'b0;
    end else begin
      rec_valid_ff <= pop_ready && pop_valid;
      if (pop_ready && pop_valid) begin
        rec_data_ff <= pop_rec;
      end
      msg_sop_ff <= pop_ready && pop_valid && (left_ff == msg_nrec_ff);
      msg_eop_ff <= pop_ready && pop_valid && (left_ff == CW'(1));
    end
  end

  // Busy from start of message until acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      msg_busy_ff <= 1'b0;
    end else begin
      msg_busy_ff <= (nxt_state != ST_IDLE);
    end
  end

  AST_NO_REC_DISABLED: assert property (@(posedge clk) disable iff (rst)
    (!rpt_expo_en && !rpt_ovr_en) |-> !push_valid)
    else $error("record queued while reporting disabled");

  AST_CHAN_ZERO: assert property (@(posedge clk) disable iff (rst)
    rec_valid_ff |-> (rec_data_ff.chan == CHAN_ID))
    else $error("stream channel not zero");

  AST_KIND_LEGAL: assert property (@(posedge clk) disable iff (rst)
    rec_valid_ff |-> (rec_data_ff.kind == KIND_EXPO_END || rec_data_ff.kind == KIND_OVERRUN))
    else $error("illegal event type");

  AST_STAMP_NOW: assert property (@(posedge clk) disable iff (rst)
    expo_take |=> (ts_ff == $past(ts_ff) + 32'h0000_0001) && ($past(push_rec.stamp) == $past(ts_ff)))
    else $error("timestamp not taken at event");

  AST_MSG_START: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_IDLE && slot_s && q_cnt != '0)
      |=> (state_ff == ST_SEND && msg_nrec_ff == $past(q_cnt) && msg_busy_ff))
    else $error("message did not start with all records");

  AST_SINGLE: assert property (@(posedge clk) disable iff (rst)
    (msg_sop_ff && msg_nrec_ff == CW'(1)) |-> msg_eop_ff ##1 !rec_valid_ff)
    else $error("single record message not closed");

  AST_RESERVE: assert property (@(posedge clk) disable iff (rst)
    (push_valid && !ovr_push) |=> (q_cnt <= CW'(DEPTH - 1)))
    else $error("normal record used reserved slot");

  AST_OVR_EN: assert property (@(posedge clk) disable iff (rst)
    (push_valid && push_rec.kind == KIND_OVERRUN) |-> (rpt_ovr_en && expo_drop && push_ready))
    else $error("overrun record without cause or enable");

  AST_DROP_FLAG: assert property (@(posedge clk) disable iff (rst)
    expo_drop |=> (overrun_ff && ovr_lat_ff && q_cnt >= CW'(DEPTH - 2)))
    else $error("dropped event not flagged");

  AST_ACK_WAIT: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_WACK && !ack_rise) |=> (state_ff == ST_WACK && !rec_valid_ff))
    else $error("left ack wait without acknowledge");

  AST_EXPO_OFF: assert property (@(posedge clk) disable iff (rst)
    (expo_done && !rpt_expo_en) |-> !push_valid)
    else $error("exposure record queued while its reporting is off");

  AST_ONLY_EXPO: assert property (@(posedge clk) disable iff (rst)
    push_valid |-> expo_evt)
    else $error("record queued without an exposure event");

  AST_EXPO_QUEUED: assert property (@(posedge clk) disable iff (rst)
    expo_take |-> (push_ready && push_rec.kind == KIND_EXPO_END))
    else $error("accepted exposure record not written to queue");

  AST_OVR_OFF: assert property (@(posedge clk) disable iff (rst)
    (push_valid && !rpt_ovr_en) |-> (push_rec.kind == KIND_EXPO_END))
    else $error("overrun record queued while its reporting is off");

  AST_OVR_ONCE: assert property (@(posedge clk) disable iff (rst)
    ovr_push |=> (ovr_lat_ff && q_cnt >= CW'(DEPTH - 1)))
    else $error("overrun record not stored in reserved slot");

  AST_OVR_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (overrun_ff && room_normal) |=> !overrun_ff)
    else $error("overrun flag stuck after room returned");

  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_IDLE && (!slot_s || q_cnt == '0))
      |=> (state_ff == ST_IDLE && !msg_busy_ff))
    else $error("message started without bus time or records");

  AST_POP_IN_MSG: assert property (@(posedge clk) disable iff (rst)
    (state_ff != ST_SEND) |-> !pop_ready)
    else $error("record drained outside a message");

  AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_IDLE) |-> !rec_valid_ff)
    else $error("record sent while no message open");

  AST_SOP_VALID: assert property (@(posedge clk) disable iff (rst)
    msg_sop_ff |-> (rec_valid_ff && msg_busy_ff))
    else $error("message start flag without record");

  AST_EOP_VALID: assert property (@(posedge clk) disable iff (rst)
    msg_eop_ff |-> (rec_valid_ff && state_ff == ST_WACK))
    else $error("message end flag without record");

  AST_LEFT_BOUND: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_SEND) |-> (left_ff != '0 && left_ff <= q_cnt && left_ff <= msg_nrec_ff))
    else $error("message record count lost");

  AST_ACK_DONE: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_WACK && ack_rise) |=> (state_ff == ST_IDLE && !msg_busy_ff))
    else $error("acknowledge did not close the message");

endmodule // cerq_top
`default_nettype wire

// ### verilog/cerq_pkg.sv
`default_nettype none
package cerq_pkg;

  // Record field widths
  localparam int unsigned KIND_W  = 8;
  localparam int unsigned CHAN_W  = 8;
  localparam int unsigned FRAME_W = 16;
  localparam int unsigned STAMP_W = 32;
  localparam int unsigned REC_W   = KIND_W + CHAN_W + FRAME_W + STAMP_W;

  // Queue depth after reset
  localparam int unsigned QUEUE_DEPTH = 8;

  // Event type codes
  localparam logic [KIND_W-1:0] KIND_EXPO_END = 8'h01;
  localparam logic [KIND_W-1:0] KIND_OVERRUN  = 8'h02;

  // Stream channel carried in every record
  localparam logic [CHAN_W-1:0] CHAN_ID = 8'h00;

  // Reset values
  localparam logic [STAMP_W-1:0] STAMP_RST = 32'h0000_0000;

  // One queued event record
  typedef struct packed {
    logic [KIND_W-1:0]  kind;
    logic [CHAN_W-1:0]  chan;
    logic [FRAME_W-1:0] frame;
    logic [STAMP_W-1:0] stamp;
  } cerq_rec_t;

  // Message framer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WACK = 2'b10
  } cerq_state_t;

endpackage
`default_nettype wire

// ### verilog/cerq_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module cerq_sync2 import cerq_pkg::*; #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,   // System clock
  input  wire logic         rst,   // Synchronous reset
  input  wire logic [W-1:0] din,   // Asynchronous levels
  output var  logic [W-1:0] dout   // Synchronised levels
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;

  // Two stage synchroniser, first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
    end
  end

  assign dout = s2_ff;

endmodule // cerq_sync2
`default_nettype wire

// ### verilog/cerq_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module cerq_fifo import cerq_pkg::*; #(
  parameter int unsigned W  = REC_W,
  parameter int unsigned D  = QUEUE_DEPTH,
  parameter int unsigned CW = $clog2(D + 1),
  parameter int unsigned AW = (D > 1) ? $clog2(D) : 1
) (
  input  wire logic          clk,        // System clock
  input  wire logic          rst,        // Synchronous reset
  input  wire logic          in_valid,   // Write request
  output var  logic          in_ready,   // Space available
  input  wire logic [W-1:0]  in_data,    // Write data
  output var  logic          out_valid,  // Data available
  input  wire logic          out_ready,  // Read request
  output var  logic [W-1:0]  out_data,   // Oldest entry
  output var  logic [CW-1:0] count       // Entries held
);

  logic [W-1:0]  mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [CW-1:0] cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_ff != CW'(D));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ff];
  assign count     = cnt_ff;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // Pointers wrap at depth, oldest first
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(D - 1)) ? '0 : wr_ff + AW'(1);
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(D - 1)) ? '0 : rd_ff + AW'(1);
      end
    end
  end

  // Fill level
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (push && !pop) begin
      cnt_ff <= cnt_ff + CW'(1);
    end else if (pop && !push) begin
      cnt_ff <= cnt_ff - CW'(1);
    end
  end

endmodule // cerq_fifo
`default_nettype wire

// ### test/cerq_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module cerq_host_model (
  input  wire logic clk,          // System clock
  input  wire logic rst,          // Synchronous reset
  input  wire logic slot_en,      // Bench grants bus time
  input  wire logic rdy_en,       // Bench lets records flow
  input  wire logic msg_eop_ff,   // Last record seen
  input  wire logic msg_busy_ff,  // Message outstanding
  output var  logic bus_slot,     // Bus time available
  output var  logic bus_rdy,      // Record accepted
  output var  logic host_ack      // Message acknowledge
);
  // Bus time and flow follow the bench
  always_ff @(posedge clk) begin
    bus_slot <= slot_en & ~rst;
    bus_rdy  <= rdy_en & ~rst;
  end
  // Acknowledge each message once its last record arrived
  always_ff @(posedge clk) begin
    if (rst) begin
      host_ack <= 1'b0;
    end else if (msg_eop_ff) begin
      host_ack <= 1'b1;
    end else if (!msg_busy_ff) begin
      host_ack <= 1'b0;
    end
  end
endmodule // cerq_host_model
`default_nettype wire

// ### test/cerq_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cerq_top_tb;
  import cerq_pkg::*;
  logic            clk, rst, expo_done, rpt_expo_en, rpt_ovr_en;
  logic            slot_en, rdy_en, bus_slot, bus_rdy, host_ack;
  logic [15:0]     frame_cnt;
  logic            rec_valid_ff, msg_sop_ff, msg_eop_ff, msg_busy_ff, overrun_ff;
  cerq_rec_t       rec_data_ff;
  logic [3:0]      msg_nrec_ff, last_nrec;
  cerq_rec_t       recs[$];
  int              msgs, fail_count, comparisons;

  cerq_top dut (.clk(clk), .rst(rst), .expo_done(expo_done), .frame_cnt(frame_cnt),
    .rpt_expo_en(rpt_expo_en), .rpt_ovr_en(rpt_ovr_en), .bus_slot(bus_slot),
    .bus_rdy(bus_rdy), .host_ack(host_ack), .rec_valid_ff(rec_valid_ff),
    .rec_data_ff(rec_data_ff), .msg_sop_ff(msg_sop_ff), .msg_eop_ff(msg_eop_ff),
    .msg_nrec_ff(msg_nrec_ff), .msg_busy_ff(msg_busy_ff), .overrun_ff(overrun_ff));
  cerq_host_model host (.clk(clk), .rst(rst), .slot_en(slot_en), .rdy_en(rdy_en),
    .msg_eop_ff(msg_eop_ff), .msg_busy_ff(msg_busy_ff), .bus_slot(bus_slot),
    .bus_rdy(bus_rdy), .host_ack(host_ack));

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Collect records and message starts as the host sees them
  always @(posedge clk) begin
    if (rec_valid_ff === 1'b1) recs.push_back(rec_data_ff);
    if (msg_sop_ff === 1'b1) begin
      msgs++;
      last_nrec = msg_nrec_ff;
    end
  end

  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    comparisons++;
    if (exp !== got) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Back-to-back exposure ends with rising frame numbers
  task automatic burst(int n, logic [15:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      expo_done <= 1'b1;
      frame_cnt <= base + 16'(i);
    end
    @(posedge clk);
    expo_done <= 1'b0;
  endtask
  // Wait for message n to start and its acknowledge to complete
  task automatic wait_msg(int n);
    int k;
    k = 0;
    while (!(msgs == n && msg_busy_ff === 1'b0) && k < 300) begin
      @(posedge clk);
      k++;
    end
    chk("message done", 1, k < 300);
  endtask
  // One record, one message; record fields from the event
  task automatic t_single();
    burst(1, 16'h1234);
    wait_msg(1);
    chk("nrec single", 4'h1, last_nrec);
    chk("kind", KIND_EXPO_END, recs[0].kind);
    chk("chan", 8'h00, recs[0].chan);
    chk("frame", 16'h1234, recs[0].frame);
  endtask
  // Reporting off yields nothing
  task automatic t_disabled();
    rpt_expo_en <= 1'b0;
    burst(2, 16'h0050);
    repeat (30) @(posedge clk);
    chk("records off", 1, recs.size());
    chk("msgs off", 1, msgs);
    rpt_expo_en <= 1'b1;
  endtask
  // Three queued records share one message, oldest first
  task automatic t_pack();
    slot_en <= 1'b0;
    repeat (4) @(posedge clk);  // Let the synchronised slot fall first
    burst(3, 16'h0100);
    repeat (5) @(posedge clk);
    slot_en <= 1'b1;
    wait_msg(2);
    chk("nrec pack", 4'h3, last_nrec);
    for (int i = 0; i < 3; i++) chk("order", 16'h0100 + i, recs[1+i].frame);
    chk("stamp rises", 1, recs[2].stamp > recs[1].stamp);
    chk("stamp step", recs[1].stamp + 32'h0000_0001, recs[2].stamp);
  endtask
  // Full queue drops events; reserved slot takes the overrun record
  task automatic t_overrun(logic ovr, int n_msg);
    int b;
    b = recs.size();
    slot_en <= 1'b0;
    rpt_ovr_en <= ovr;
    repeat (4) @(posedge clk);  // Let the synchronised slot fall first
    burst(9, 16'h0200);
    @(posedge clk);
    chk("overrun flag", 1'b1, overrun_ff);
    slot_en <= 1'b1;
    wait_msg(n_msg);
    chk("nrec full", ovr ? 4'h8 : 4'h7, last_nrec);
    for (int i = 0; i < 7; i++) chk("kept frame", 16'h0200 + i, recs[b+i].frame);
    if (ovr) begin
      chk("ovr kind", KIND_OVERRUN, recs[b+7].kind);
      chk("ovr chan", 8'h00, recs[b+7].chan);
      chk("ovr frame", 16'h0207, recs[b+7].frame);
    end
    chk("overrun clear", 1'b0, overrun_ff);
  endtask

  task automatic finish_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    expo_done = 1'b0;
    frame_cnt = 16'h0000;
    rpt_expo_en = 1'b1;
    rpt_ovr_en = 1'b1;
    slot_en = 1'b0;
    rdy_en = 1'b1;
    msgs = 0;
    fail_count = 0;
    comparisons = 0;
    last_nrec = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    slot_en <= 1'b1;
    repeat (2) @(posedge clk);
    t_single();
    t_disabled();
    t_pack();
    t_overrun(1'b1, 3);
    t_overrun(1'b0, 4);
    finish_test();
  end
endmodule // cerq_top_tb
`default_nettype wire
